// ---- rtl/port_priority_tag_control.sv ----
// Per-port priority classification, tag edit and queue split control
// How it works
// - DiffServ enable bit lets a port classify ingress frames by code point.
// - 802.1p enable bit lets a port classify ingress frames by tag priority.
// - Two-bit default priority applies when classifiers are off or miss.
// - All may be on; DiffServ and 802.1p results OR'ed replace default.
// - Tag insertion adds a tag to frames that arrived untagged.
// - Tag insertion never adds a second tag to frames that arrived tagged.
// - Inserted tag carries the ingress port default VLAN id.
// - Tag removal strips the tag from frames that arrived tagged.
// - Tag removal leaves frames that arrived untagged unchanged.
// - Queue split code is companion bit 1 above control bit 0.
// - Code 10 gives four queues, 01 two queues, 11 is reserved.
// - Code 00 gives one queue with no priority ordering.
// - One control register per port at 0x10, 0x20, 0x30 and 0x50.
`timescale 1ns/1ps

module port_priority_tag_control #(
    parameter int NUM_PORTS = port_ctrl_pkg::NUM_PORTS
) (
    input  wire logic                                ref_clk,
    input  wire logic                                rst_n,
    input  wire logic [port_ctrl_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [port_ctrl_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [port_ctrl_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic                                cls_valid,
    input  wire logic [port_ctrl_pkg::PORT_IDX_W-1:0] cls_port,
    input  wire logic                                cls_dscp_hit,
    input  wire logic [port_ctrl_pkg::PRIO_W-1:0]    cls_dscp_prio,
    input  wire logic                                cls_pcp_hit,
    input  wire logic [port_ctrl_pkg::PRIO_W-1:0]    cls_pcp_prio,
    output logic                                     cls_done,
    output logic      [port_ctrl_pkg::PRIO_W-1:0]    cls_prio,
    input  wire logic                                eg_valid,
    input  wire logic [port_ctrl_pkg::PORT_IDX_W-1:0] eg_port,
    input  wire logic [port_ctrl_pkg::PORT_IDX_W-1:0] eg_ingress_port,
    input  wire logic                                eg_rx_tagged,
    input  wire logic [port_ctrl_pkg::PRIO_W-1:0]    eg_prio,
    output logic                                     eg_done,
    output logic                                     eg_insert_tag,
    output logic                                     eg_strip_tag,
    output logic      [port_ctrl_pkg::VID_W-1:0]     eg_vid,
    output port_ctrl_pkg::queue_mode_type            eg_queue_mode,
    output logic      [port_ctrl_pkg::PRIO_W-1:0]    eg_queue_sel,
    output logic                                     eg_code_reserved
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [port_ctrl_pkg::DATA_W-1:0] ctrl_q     [NUM_PORTS];
    logic [port_ctrl_pkg::VID_W-1:0]  vid_q      [NUM_PORTS];
    logic [NUM_PORTS-1:0]             qsplit_hi_q;
    logic [NUM_PORTS-1:0]             ctrl_hit;
    logic [NUM_PORTS-1:0]             vid_lo_hit;
    logic [NUM_PORTS-1:0]             vid_hi_hit;
    logic [port_ctrl_pkg::DATA_W-1:0] rd_term    [NUM_PORTS];
    logic [port_ctrl_pkg::DATA_W-1:0] rd_ports;
    logic [port_ctrl_pkg::DATA_W-1:0] rd_word;
    logic                             qsplit_hit;
    logic                             any_hit;

    // ------------------------------------------------------------------
    // Address decode and per-port registers
    // ------------------------------------------------------------------
    assign qsplit_hit = (reg_addr == port_ctrl_pkg::QSPLIT_HI_ADDR);

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            localparam logic [port_ctrl_pkg::ADDR_W-1:0] VLO =
                port_ctrl_pkg::ADDR_W'(port_ctrl_pkg::VID_LO_BASE
                    + p * port_ctrl_pkg::VID_STEP);
            localparam logic [port_ctrl_pkg::ADDR_W-1:0] VHI =
                port_ctrl_pkg::ADDR_W'(port_ctrl_pkg::VID_HI_BASE
                    + p * port_ctrl_pkg::VID_STEP);

            assign ctrl_hit[p]   = (reg_addr == port_ctrl_pkg::CTRL_ADDR[p]);
            assign vid_lo_hit[p] = (reg_addr == VLO);
            assign vid_hi_hit[p] = (reg_addr == VHI);

            assign rd_term[p] =
                ({port_ctrl_pkg::DATA_W{ctrl_hit[p]}} & ctrl_q[p])
                | ({port_ctrl_pkg::DATA_W{vid_lo_hit[p]}}
                   & vid_q[p][port_ctrl_pkg::DATA_W-1:0])
                | ({port_ctrl_pkg::DATA_W{vid_hi_hit[p]}}
                   & {{(port_ctrl_pkg::DATA_W-port_ctrl_pkg::VID_HI_W){1'b0}},
                      vid_q[p][port_ctrl_pkg::VID_W-1:port_ctrl_pkg::DATA_W]});

            // Control register, storm bit not held
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    ctrl_q[p] <= port_ctrl_pkg::CTRL_RESET;
                else if (reg_wr && ctrl_hit[p])
                    ctrl_q[p] <= reg_wdata & port_ctrl_pkg::CTRL_WMASK;
            end

            // Default VLAN id, low and high bytes
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    vid_q[p] <= port_ctrl_pkg::VID_RESET;
                else if (reg_wr && vid_lo_hit[p])
                    vid_q[p][port_ctrl_pkg::DATA_W-1:0] <= reg_wdata;
                else if (reg_wr && vid_hi_hit[p])
                    vid_q[p][port_ctrl_pkg::VID_W-1:port_ctrl_pkg::DATA_W] <=
                        reg_wdata[port_ctrl_pkg::VID_HI_W-1:0];
            end

            // Companion upper split bit
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    qsplit_hi_q[p] <= port_ctrl_pkg::QHI_RESET[p];
                else if (reg_wr && qsplit_hit)
                    qsplit_hi_q[p] <= reg_wdata[p];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_ports = '0;
        for (int i = 0; i < NUM_PORTS; i++)
            rd_ports = rd_ports | rd_term[i];
    end

    assign any_hit = (|ctrl_hit) | (|vid_lo_hit) | (|vid_hi_hit) | qsplit_hit;
    assign rd_word = !any_hit ? port_ctrl_pkg::RD_UNMAPPED
                   : qsplit_hit
                   ? {{(port_ctrl_pkg::DATA_W-NUM_PORTS){1'b0}}, qsplit_hi_q}
                   : rd_ports;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= port_ctrl_pkg::RD_UNMAPPED;
        else if (reg_rd)
            reg_rdata <= rd_word;
        else
            reg_rdata <= port_ctrl_pkg::RD_UNMAPPED;
    end

    // ------------------------------------------------------------------
    // Ingress classification
    // ------------------------------------------------------------------
    logic [port_ctrl_pkg::DATA_W-1:0] cls_ctrl;
    logic                             dscp_use;
    logic                             pcp_use;
    logic [port_ctrl_pkg::PRIO_W-1:0] dscp_val;
    logic [port_ctrl_pkg::PRIO_W-1:0] pcp_val;
    logic [port_ctrl_pkg::PRIO_W-1:0] def_prio;
    logic [port_ctrl_pkg::PRIO_W-1:0] cls_prio_d;

    assign cls_ctrl   = ctrl_q[cls_port];
    assign dscp_use   = cls_ctrl[port_ctrl_pkg::DSCP_EN_BIT] & cls_dscp_hit;
    assign pcp_use    = cls_ctrl[port_ctrl_pkg::PCP_EN_BIT] & cls_pcp_hit;
    assign dscp_val   = dscp_use ? cls_dscp_prio : port_ctrl_pkg::PRIO_ZERO;
    assign pcp_val    = pcp_use ? cls_pcp_prio : port_ctrl_pkg::PRIO_ZERO;
    assign def_prio   = cls_ctrl[port_ctrl_pkg::DEF_PRIO_MSB:
                                 port_ctrl_pkg::DEF_PRIO_LSB];
    assign cls_prio_d = (dscp_use | pcp_use) ? (dscp_val | pcp_val)
                                             : def_prio;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cls_done <= 1'b0;
            cls_prio <= port_ctrl_pkg::PRIO_ZERO;
        end
        else
        begin
            cls_done <= cls_valid;
            if (cls_valid)
                cls_prio <= cls_prio_d;
        end
    end

    // ------------------------------------------------------------------
    // Egress tag edit and queue split
    // ------------------------------------------------------------------
    logic [port_ctrl_pkg::DATA_W-1:0] eg_ctrl;
    logic                             insert_d;
    logic                             strip_d;
    port_ctrl_pkg::queue_mode_type    mode_d;
    logic [port_ctrl_pkg::PRIO_W-1:0] qsel_d;

    assign eg_ctrl  = ctrl_q[eg_port];
    assign insert_d = eg_ctrl[port_ctrl_pkg::TAG_INS_BIT] & ~eg_rx_tagged;
    assign strip_d  = eg_ctrl[port_ctrl_pkg::TAG_REM_BIT] & eg_rx_tagged;
    assign mode_d   = port_ctrl_pkg::queue_mode_type'(
        {qsplit_hi_q[eg_port], eg_ctrl[port_ctrl_pkg::QSPLIT_LO_BIT]});
    assign qsel_d   = (mode_d == port_ctrl_pkg::QM_FOUR) ? eg_prio
                    : (mode_d == port_ctrl_pkg::QM_TWO)
                    ? {1'b0, eg_prio[port_ctrl_pkg::PRIO_W-1]}
                    : port_ctrl_pkg::PRIO_ZERO;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eg_done          <= 1'b0;
            eg_insert_tag    <= 1'b0;
            eg_strip_tag     <= 1'b0;
            eg_vid           <= '0;
            eg_queue_mode    <= port_ctrl_pkg::QM_SINGLE;
            eg_queue_sel     <= port_ctrl_pkg::PRIO_ZERO;
            eg_code_reserved <= 1'b0;
        end
        else
        begin
            eg_done <= eg_valid;
            if (eg_valid)
            begin
                eg_insert_tag    <= insert_d;
                eg_strip_tag     <= strip_d;
                eg_vid           <= vid_q[eg_ingress_port];
                eg_queue_mode    <= mode_d;
                eg_queue_sel     <= qsel_d;
                eg_code_reserved <= (mode_d == port_ctrl_pkg::QM_RSVD);
            end
        end
    end

endmodule : port_priority_tag_control

// ---- common/port_ctrl_pkg.sv ----
// Shared constants and types of the per-port priority and tag control block
package port_ctrl_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_PORTS    = 4;
    localparam int PORT_IDX_W   = 2;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 8;
    localparam int PRIO_W       = 2;
    localparam int VID_W        = 12;
    localparam int VID_HI_W     = 4;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] CTRL_ADDR =
        {8'h50, 8'h30, 8'h20, 8'h10};
    localparam logic [ADDR_W-1:0] QSPLIT_HI_ADDR = 8'h60;
    localparam logic [ADDR_W-1:0] VID_LO_BASE    = 8'h64;
    localparam logic [ADDR_W-1:0] VID_HI_BASE    = 8'h68;
    localparam logic [ADDR_W-1:0] VID_STEP       = 8'h08;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int DSCP_EN_BIT    = 6;
    localparam int PCP_EN_BIT     = 5;
    localparam int DEF_PRIO_MSB   = 4;
    localparam int DEF_PRIO_LSB   = 3;
    localparam int TAG_INS_BIT    = 2;
    localparam int TAG_REM_BIT    = 1;
    localparam int QSPLIT_LO_BIT  = 0;

    localparam logic [DATA_W-1:0]   CTRL_WMASK  = 8'h7f;
    localparam logic [DATA_W-1:0]   CTRL_RESET  = 8'h00;
    localparam logic [NUM_PORTS-1:0] QHI_RESET  = 4'h0;
    localparam logic [VID_W-1:0]    VID_RESET   = 12'h001;
    localparam logic [DATA_W-1:0]   RD_UNMAPPED = 8'h00;
    localparam logic [PRIO_W-1:0]   PRIO_ZERO   = 2'h0;

    // ------------------------------------------------------------------
    // Queue split codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        QM_SINGLE = 2'b00,
        QM_TWO    = 2'b01,
        QM_FOUR   = 2'b10,
        QM_RSVD   = 2'b11
    } queue_mode_type;

endpackage : port_ctrl_pkg

// ---- bench/port_ctrl_sva.sv ----
// Concurrent checks on the control block ports
`timescale 1ns/1ps

module port_ctrl_sva (
    input wire logic                         ref_clk,
    input wire logic                         rst_n,
    input wire logic                         reg_rd,
    input wire logic [7:0]                   reg_rdata,
    input wire logic                         cls_valid,
    input wire logic                         cls_done,
    input wire logic [1:0]                   cls_prio,
    input wire logic                         eg_valid,
    input wire logic                         eg_rx_tagged,
    input wire logic [1:0]                   eg_prio,
    input wire logic                         eg_done,
    input wire logic                         eg_insert_tag,
    input wire logic                         eg_strip_tag,
    input wire logic [11:0]                  eg_vid,
    input wire port_ctrl_pkg::queue_mode_type eg_queue_mode,
    input wire logic [1:0]                   eg_queue_sel,
    input wire logic                         eg_code_reserved
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence eg_req;
        eg_valid ##1 eg_done;
    endsequence

    rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    cls_answer_a: assert property (cls_done == $past(cls_valid))
        else $error("classify done not one cycle after request");
    eg_answer_a: assert property (eg_done == $past(eg_valid))
        else $error("egress done not one cycle after request");
    tag_excl_a: assert property (eg_done |-> !(eg_insert_tag && eg_strip_tag))
        else $error("insert and strip together");
    no_dbl_tag_a: assert property (eg_valid && eg_rx_tagged |=> !eg_insert_tag)
        else $error("tag added to tagged frame");
    untag_keep_a: assert property (eg_valid && !eg_rx_tagged |=> !eg_strip_tag)
        else $error("strip on untagged frame");
    four_sel_a: assert property (
        eg_req ##0 eg_queue_mode == port_ctrl_pkg::QM_FOUR
        |-> eg_queue_sel == $past(eg_prio))
        else $error("four queue select wrong");
    two_sel_a: assert property (
        eg_req ##0 eg_queue_mode == port_ctrl_pkg::QM_TWO
        |-> eg_queue_sel == ($past(eg_prio) >> 1))
        else $error("two queue select wrong");
    one_sel_a: assert property (
        eg_done && (eg_code_reserved ||
        eg_queue_mode == port_ctrl_pkg::QM_SINGLE) |-> eg_queue_sel == 2'h0)
        else $error("single queue select not zero");
    eg_hold_a: assert property (!eg_valid |=> $stable(eg_vid) && $stable(eg_queue_sel))
        else $error("egress result changed without request");
    cls_hold_a: assert property (!cls_valid |=> $stable(cls_prio))
        else $error("priority changed without request");
endmodule : port_ctrl_sva

bind port_priority_tag_control port_ctrl_sva port_ctrl_sva_inst (.*);

// ---- bench/port_priority_tag_control_tb.sv ----
// Self-checking bench of the control block
`timescale 1ns/1ps

module port_priority_tag_control_tb;
    typedef struct packed {
        logic [1:0] p; logic [7:0] c; logic q; logic [5:0] k;
        logic [1:0] x; logic [1:0] ip; logic t; logic [1:0] pr; logic [6:0] eo;
    } row_type;
    localparam row_type ROWS [6] = '{
        '{2'h0, 8'h18, 1'b0, 6'h2e, 2'h3, 2'h1, 1'b0, 2'h0, 7'h00},
        '{2'h1, 8'h44, 1'b0, 6'h2e, 2'h1, 2'h3, 1'b0, 2'h0, 7'h40},
        '{2'h2, 8'h23, 1'b0, 6'h3e, 2'h2, 2'h0, 1'b1, 2'h3, 7'h2a},
        '{2'h3, 8'h6c, 1'b1, 6'h2e, 2'h3, 2'h2, 1'b1, 2'h2, 7'h14},
        '{2'h0, 8'h73, 1'b0, 6'h1b, 2'h2, 2'h3, 1'b0, 2'h2, 7'h0a},
        '{2'h1, 8'h78, 1'b1, 6'h23, 2'h0, 2'h2, 1'b1, 2'h1, 7'h12}};
    logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic cls_valid = 1'b0, cls_dscp_hit = 1'b0, cls_pcp_hit = 1'b0, cls_done;
    logic [1:0] cls_port = 2'h0, cls_dscp_prio = 2'h0, cls_pcp_prio = 2'h0;
    logic [1:0] eg_port = 2'h0, eg_ingress_port = 2'h0, eg_prio = 2'h0;
    logic eg_valid = 1'b0, eg_rx_tagged = 1'b0, eg_done, eg_insert_tag;
    logic eg_strip_tag, eg_code_reserved;
    logic [1:0] cls_prio, eg_queue_sel;
    logic [11:0] eg_vid;
    port_ctrl_pkg::queue_mode_type eg_queue_mode;
    int failures = 0, checked = 0, cyc = 0;

    port_priority_tag_control port_priority_tag_control_inst (.*);

    always #20 ref_clk = ~ref_clk;

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd

    task automatic fire(input row_type r);
        @(posedge ref_clk);
        cls_port <= r.p; eg_port <= r.p; eg_ingress_port <= r.ip;
        {cls_dscp_hit, cls_dscp_prio, cls_pcp_hit, cls_pcp_prio} <= r.k;
        eg_rx_tagged <= r.t; eg_prio <= r.pr; cls_valid <= 1'b1; eg_valid <= 1'b1;
        @(posedge ref_clk);
        cls_valid <= 1'b0; eg_valid <= 1'b0;
        #1 chk({cls_done, eg_done}, 2'h3);
    endtask : fire

    task automatic report_and_stop;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            failures++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
            rd(port_ctrl_pkg::CTRL_ADDR[i], 8'h00);
        rd(port_ctrl_pkg::VID_LO_BASE, 8'h01);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(port_ctrl_pkg::VID_LO_BASE + 8'(8 * i), 8'ha0 + 8'(i));
            wr(port_ctrl_pkg::VID_HI_BASE + 8'(8 * i), 8'hf1 + 8'(i));
            rd(port_ctrl_pkg::VID_HI_BASE + 8'(8 * i), 8'h01 + 8'(i));
        end
        $display("reset and map test done");
        foreach (ROWS[i])
        begin
            wr(port_ctrl_pkg::CTRL_ADDR[ROWS[i].p], ROWS[i].c | 8'h80);
            wr(port_ctrl_pkg::QSPLIT_HI_ADDR, {7'h00, ROWS[i].q} << ROWS[i].p);
            rd(port_ctrl_pkg::CTRL_ADDR[ROWS[i].p], ROWS[i].c);
            fire(ROWS[i]);
            chk(cls_prio, ROWS[i].x);
            chk({eg_insert_tag, eg_strip_tag, eg_queue_mode, eg_queue_sel,
                eg_code_reserved}, ROWS[i].eo);
            chk(eg_vid, {4'(ROWS[i].ip + 1), 8'ha0 + 8'(ROWS[i].ip)});
            $display("row %0d test done", i);
        end
        wr(port_ctrl_pkg::CTRL_ADDR[2], 8'h01);
        wr(port_ctrl_pkg::QSPLIT_HI_ADDR, 8'h04);
        fire('{2'h2, 8'h01, 1'b1, 6'h00, 2'h0, 2'h0, 1'b0, 2'h3, 7'h00});
        chk({eg_code_reserved, eg_queue_sel}, 3'h4);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1 chk(eg_vid, 12'h000);
        rd(port_ctrl_pkg::CTRL_ADDR[3], 8'h00);
        $display("reserved code and reset test done");
        report_and_stop();
    end
endmodule : port_priority_tag_control_tb
